// ===== test/jsr_props.sv
`include "jsr_cfg.svh"
`default_nettype none
module jsr_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  // next tap state, one nibble per state, for tms high and tms low
  localparam logic [63:0] T1 = 64'h2FEF_CC02_8785_5920;
  localparam logic [63:0] T0 = 64'h1BDD_BBA1_4664_4311;
  jsr_pkg::jsr_tap_e st_ff;
  jsr_pkg::jsr_tap_e nxt_st;
  logic              tck_ff;
  logic [15:0]       cnt_ff;
  logic [9:0]        irsh_ff;
  logic [9:0]        ir_ff;
  wire logic [63:0]  tbl;
  wire logic         rise;
  assign tbl    = tms ? T1 : T0;
  assign nxt_st = jsr_pkg::jsr_tap_e'(tbl[{st_ff, 2'b00} +: 4]);
  assign rise   = tck & ~tck_ff;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tck_ff  <= 1'b0;
      st_ff   <= jsr_pkg::TLR;
      cnt_ff  <= 16'h0;
      irsh_ff <= 10'h0;
      ir_ff   <= `JSR_OP_BYPASS;
    end else begin
      tck_ff <= tck;
      if (rise) begin
        st_ff   <= nxt_st;
        cnt_ff  <= (nxt_st == st_ff) ? cnt_ff + 16'h1 : 16'h0;
        irsh_ff <= (st_ff == jsr_pkg::SH_IR) ? {tdi, irsh_ff[9:1]} : irsh_ff;
        ir_ff   <= (nxt_st == jsr_pkg::TLR) ? `JSR_OP_BYPASS :
                   (st_ff == jsr_pkg::UPD_IR) ? irsh_ff : ir_ff;
      end
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  AST_TMS_EDGE: assert property ($changed(tms) |-> $fell(tck))
    else $error("tms changed away from a tck fall");
  AST_TDI_EDGE: assert property ($changed(tdi) |-> $fell(tck))
    else $error("tdi changed away from a tck fall");
  AST_TCK_HIGH: assert property ($rose(tck) |-> tck[*4])
    else $error("tck high phase too short");
  AST_TCK_LOW: assert property ($fell(tck) |-> !tck[*4])
    else $error("tck low phase too short");
  AST_TDO_HOLD: assert property ($rose(tck) |-> ##2 $stable(tdo)[*2])
    else $error("tdo moved while tck high");
  AST_TDO_QUIET: assert property (rise && !(st_ff inside {jsr_pkg::SH_DR, jsr_pkg::SH_IR})
      |-> ##3 !tdo)
    else $error("tdo high outside a shift state");
  AST_IR_LEN: assert property (rise && st_ff == jsr_pkg::SH_IR && tms |-> cnt_ff == 16'h0009)
    else $error("instruction shift not ten bits");
  AST_CFG_LEN: assert property (rise && st_ff == jsr_pkg::SH_DR && tms
      && ir_ff == `JSR_OP_CFG_IN |-> cnt_ff == 16'h00FF)
    else $error("packet shift not eight words");
  AST_RTI_HOLD: assert property (rise && st_ff == jsr_pkg::RTI && tms
      && (ir_ff == `JSR_OP_SHUTDOWN || ir_ff == `JSR_OP_STARTUP) |-> cnt_ff == 16'h000B)
    else $error("idle hold not twelve tck");
  AST_IR_CODE: assert property (rise && st_ff == jsr_pkg::UPD_IR |-> irsh_ff inside
      {`JSR_OP_SHUTDOWN, `JSR_OP_CFG_IN, `JSR_OP_CFG_OUT, `JSR_OP_STARTUP})
    else $error("unexpected instruction loaded");
endmodule : jsr_props
`default_nettype wire

// ===== test/jtag_shutdown_readback_seq_bench.sv
`include "jsr_cfg.svh"
`default_nettype none
module jtag_shutdown_readback_seq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CFG_EXP [16] = '{`JSR_SETUP_W0, `JSR_SETUP_W1, `JSR_SETUP_W2,
    `JSR_SETUP_W3, `JSR_SETUP_W4, `JSR_SETUP_W5, `JSR_SETUP_W6, `JSR_SETUP_W7,
    `JSR_RESTART_W0, `JSR_RESTART_W1, `JSR_RESTART_W2, `JSR_RESTART_W3,
    `JSR_RESTART_W4, `JSR_RESTART_W5, `JSR_RESTART_W6, `JSR_RESTART_W7};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  logic [31:0] rb_bits = 32'h0;
  logic        rd_ready = 1'b1;
  logic        slow = 1'b0;
  logic        fclr = 1'b0;
  logic [31:0] frame_data = 32'hC0DE_0000;
  logic        tck_q = 1'b0;
  logic [9:0]  cyc = 10'h0;
  logic        frame_take, cfg_valid, sd_done, su_done, busy, done, rd_valid;
  logic [31:0] cfg_word, rd_word;
  int          error_cnt = 0;
  int          compares = 0;
  int          fidx, rd_k, cfg_n, sd_n, su_n, rises, tms_run, hi_run, stalls;
  always #2 clk = ~clk;
  jsr_link_if jsr_link_if_i ();
  jsr_dev jsr_dev_i (.clk_in(clk), .nrst_in(nrst), .link(jsr_link_if_i),
    .frame_data_in(frame_data), .frame_take_out(frame_take), .cfg_word_out(cfg_word),
    .cfg_valid_out(cfg_valid), .shutdown_done_out(sd_done), .startup_done_out(su_done));
  jsr_host jsr_host_i (.clk_in(clk), .nrst_in(nrst), .link(jsr_link_if_i),
    .start_in(start), .rb_bits_in(rb_bits), .busy_out(busy), .done_out(done),
    .rd_word_out(rd_word), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready));
  jsr_props jsr_props_i (.clk_in(clk), .nrst_in(nrst), .tck(jsr_link_if_i.tck),
    .tms(jsr_link_if_i.tms), .tdi(jsr_link_if_i.tdi), .tdo(jsr_link_if_i.tdo));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // user sides: frame source, read sink, link observation
  always @(posedge clk) begin
    cyc <= cyc + 10'h1;
    rd_ready <= !slow || (cyc == 10'h0);
    if (fclr) begin
      fidx = 0;
      rd_k = 0;
      cfg_n = 0;
      sd_n = 0;
      su_n = 0;
      rises = 0;
      stalls = 0;
    end else begin
      if (frame_take) fidx++;
      if (rd_valid && rd_ready) begin
        check(rd_word, 32'hC0DE_0000 + `JSR_FRAME_WORDS + rd_k);
        rd_k++;
      end
      if (cfg_valid) begin
        check(cfg_word, (cfg_n < 16) ? CFG_EXP[cfg_n[3:0]] : 32'h0);
        cfg_n++;
      end
      if (sd_done) sd_n++;
      if (su_done) su_n++;
      if (jsr_link_if_i.tck && !tck_q) begin
        rises++;
        tms_run = jsr_link_if_i.tms ? tms_run + 1 : 0;
      end
      // tck rests high between sequences; only a running sequence can stall
      hi_run = (jsr_link_if_i.tck && busy) ? hi_run + 1 : 0;
      if (hi_run > 8) stalls++;
    end
    tck_q = jsr_link_if_i.tck;
    frame_data <= 32'hC0DE_0000 + fidx;
  end
  // whole sequence; a second start while busy must be ignored
  task automatic run_seq(input logic [31:0] bits, input logic slw, input int words);
    int n;
    fclr <= 1'b1;
    rb_bits <= bits;
    slow <= slw;
    @(posedge clk);
    fclr <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    check({31'h0, busy}, 32'h1);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n < 40000}, 32'h1);
    repeat (2100) @(posedge clk);
    check({31'h0, busy}, 32'h0);
    check(rd_k, words);
    check(rises, 32'h27A + bits);
    check(tms_run, 32'h5);
    check(cfg_n, 32'h10);
    check(sd_n, 32'h1);
    check(su_n, 32'h1);
    check({31'h0, stalls != 0}, {31'h0, slw});
  endtask : run_seq
  // reset in mid-sequence returns the link to tck low, tms high
  task automatic mid_reset();
    fclr <= 1'b1;
    rb_bits <= 32'h100;
    @(posedge clk);
    fclr <= 1'b0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (1500) @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    check({29'h0, busy, jsr_link_if_i.tck, jsr_link_if_i.tms}, 32'h1);
    nrst <= 1'b1;
    @(posedge clk);
  endtask : mid_reset
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run_seq(32'h100, 1'b0, 4);
    run_seq(32'h190, 1'b1, 8);
    mid_reset();
    run_seq(32'h80, 1'b0, 0);
    conclude();
  end
endmodule : jtag_shutdown_readback_seq_bench
`default_nettype wire

// ===== verilog/jsr_cfg.svh
`ifndef JSR_CFG_SVH
`define JSR_CFG_SVH
`define JSR_IR_W          10
`define JSR_OP_SHUTDOWN   10'h3CD
`define JSR_OP_CFG_IN     10'h3C5
`define JSR_OP_CFG_OUT    10'h3C4
`define JSR_OP_STARTUP    10'h3CC
`define JSR_OP_BYPASS     10'h3FF
`define JSR_IR_CAPTURE    10'h001
`define JSR_TLR_TCKS      32'h0000_0005
`define JSR_RTI_TCKS      8'h0C
`define JSR_WORD_LAST     5'h1F
`define JSR_PKT_BITS      32'h0000_0100
`define JSR_TCK_DIV       4
`define JSR_FRAME_WORDS   32'h0000_0004
`define JSR_SETUP_W0      32'hAA99_5566
`define JSR_SETUP_W1      32'h3000_2001
`define JSR_SETUP_W2      32'h0000_0000
`define JSR_SETUP_W3      32'h3000_8001
`define JSR_SETUP_W4      32'h0000_0007
`define JSR_SETUP_W5      32'h2800_6000
`define JSR_SETUP_W6      32'h4802_22FA
`define JSR_SETUP_W7      32'h2000_0000
`define JSR_RESTART_W0    32'h2000_0000
`define JSR_RESTART_W1    32'h3000_8001
`define JSR_RESTART_W2    32'h0000_0005
`define JSR_RESTART_W3    32'h3000_8001
`define JSR_RESTART_W4    32'h0000_0007
`define JSR_RESTART_W5    32'h3000_8001
`define JSR_RESTART_W6    32'h0000_0000
`define JSR_RESTART_W7    32'h2000_0000
`endif

// ===== verilog/jsr_dev.sv
`include "jsr_cfg.svh"
`default_nettype none
module jsr_dev #(
  parameter int              IR_W        = `JSR_IR_W,
  parameter logic [IR_W-1:0] OP_SHUTDOWN = `JSR_OP_SHUTDOWN,
  parameter logic [IR_W-1:0] OP_CFG_IN   = `JSR_OP_CFG_IN,
  parameter logic [IR_W-1:0] OP_CFG_OUT  = `JSR_OP_CFG_OUT,
  parameter logic [IR_W-1:0] OP_STARTUP  = `JSR_OP_STARTUP,
  parameter logic [IR_W-1:0] OP_BYPASS   = `JSR_OP_BYPASS,
  parameter logic [IR_W-1:0] IR_CAPTURE  = `JSR_IR_CAPTURE
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  jsr_link_if.dev          link,
  input  wire logic [31:0] frame_data_in,
  output logic             frame_take_out,
  output logic [31:0]      cfg_word_out,
  output logic             cfg_valid_out,
  output logic             shutdown_done_out,
  output logic             startup_done_out
);
  function automatic jsr_pkg::jsr_tap_e tap_next(input jsr_pkg::jsr_tap_e s, input logic m);
    case (s)
      jsr_pkg::TLR:    tap_next = m ? jsr_pkg::TLR    : jsr_pkg::RTI;
      jsr_pkg::RTI:    tap_next = m ? jsr_pkg::SEL_DR : jsr_pkg::RTI;
      jsr_pkg::SEL_DR: tap_next = m ? jsr_pkg::SEL_IR : jsr_pkg::CAP_DR;
      jsr_pkg::CAP_DR: tap_next = m ? jsr_pkg::EX1_DR : jsr_pkg::SH_DR;
      jsr_pkg::SH_DR:  tap_next = m ? jsr_pkg::EX1_DR : jsr_pkg::SH_DR;
      jsr_pkg::EX1_DR: tap_next = m ? jsr_pkg::UPD_DR : jsr_pkg::PA_DR;
      jsr_pkg::PA_DR:  tap_next = m ? jsr_pkg::EX2_DR : jsr_pkg::PA_DR;
      jsr_pkg::EX2_DR: tap_next = m ? jsr_pkg::UPD_DR : jsr_pkg::SH_DR;
      jsr_pkg::UPD_DR: tap_next = m ? jsr_pkg::SEL_DR : jsr_pkg::RTI;
      jsr_pkg::SEL_IR: tap_next = m ? jsr_pkg::TLR    : jsr_pkg::CAP_IR;
      jsr_pkg::CAP_IR: tap_next = m ? jsr_pkg::EX1_IR : jsr_pkg::SH_IR;
      jsr_pkg::SH_IR:  tap_next = m ? jsr_pkg::EX1_IR : jsr_pkg::SH_IR;
      jsr_pkg::EX1_IR: tap_next = m ? jsr_pkg::UPD_IR : jsr_pkg::PA_IR;
      jsr_pkg::PA_IR:  tap_next = m ? jsr_pkg::EX2_IR : jsr_pkg::PA_IR;
      jsr_pkg::EX2_IR: tap_next = m ? jsr_pkg::UPD_IR : jsr_pkg::SH_IR;
      jsr_pkg::UPD_IR: tap_next = m ? jsr_pkg::SEL_DR : jsr_pkg::RTI;
      default:         tap_next = jsr_pkg::TLR;
    endcase
  endfunction : tap_next

  logic             tck_s1_ff, tck_s2_ff, tck_d_ff;
  logic             tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff;
  jsr_pkg::jsr_tap_e state_ff;
  logic [IR_W-1:0]  ir_sr_ff, instr_ff;
  logic [31:0]      in_sr_ff, out_sr_ff;
  logic [4:0]       dr_cnt_ff;
  logic [7:0]       rti_cnt_ff;
  logic             tdo_ff;

  // tck edges seen on the synchronised copy; tms/tdi share its delay
  wire rise     = tck_s2_ff & ~tck_d_ff;
  wire fall     = ~tck_s2_ff & tck_d_ff;
  wire sel_in   = (instr_ff == OP_CFG_IN);
  wire sel_out  = (instr_ff == OP_CFG_OUT);
  wire sel_shut = (instr_ff == OP_SHUTDOWN);
  wire sel_strt = (instr_ff == OP_STARTUP);
  wire in_sh_dr = (state_ff == jsr_pkg::SH_DR);
  wire word_end = (dr_cnt_ff == `JSR_WORD_LAST);
  wire rti_hit  = (state_ff == jsr_pkg::RTI) && (rti_cnt_ff == `JSR_RTI_TCKS - 8'h01);
  wire [31:0] in_next = {in_sr_ff[30:0], tdi_s2_ff};

  assign link.tdo = tdo_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {tck_s1_ff, tck_s2_ff, tck_d_ff} <= 3'h0;
      {tms_s1_ff, tms_s2_ff, tdi_s1_ff, tdi_s2_ff} <= 4'hF;
    end else begin
      {tck_s1_ff, tck_s2_ff, tck_d_ff} <= {link.tck, tck_s1_ff, tck_s2_ff};
      {tms_s1_ff, tms_s2_ff} <= {link.tms, tms_s1_ff};
      {tdi_s1_ff, tdi_s2_ff} <= {link.tdi, tdi_s1_ff};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= jsr_pkg::TLR;
      ir_sr_ff <= IR_CAPTURE;
      instr_ff <= OP_BYPASS;
    end else if (rise) begin
      state_ff <= tap_next(state_ff, tms_s2_ff);
      case (state_ff)
        jsr_pkg::TLR:    instr_ff <= OP_BYPASS;
        jsr_pkg::CAP_IR: ir_sr_ff <= IR_CAPTURE;
        jsr_pkg::SH_IR:  ir_sr_ff <= {tdi_s2_ff, ir_sr_ff[IR_W-1:1]};
        jsr_pkg::UPD_IR: instr_ff <= ir_sr_ff;
        default:         ir_sr_ff <= ir_sr_ff;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      in_sr_ff       <= 32'h0000_0000;
      out_sr_ff      <= 32'h0000_0000;
      dr_cnt_ff      <= 5'h00;
      cfg_word_out   <= 32'h0000_0000;
      cfg_valid_out  <= 1'b0;
      frame_take_out <= 1'b0;
    end else begin
      cfg_valid_out  <= 1'b0;
      frame_take_out <= 1'b0;
      if (rise && state_ff == jsr_pkg::CAP_DR) begin
        dr_cnt_ff <= 5'h00;
        if (sel_out) begin
          out_sr_ff      <= frame_data_in;
          frame_take_out <= 1'b1;
        end
      end else if (rise && in_sh_dr) begin
        dr_cnt_ff <= dr_cnt_ff + 5'h01;
        if (sel_in) begin
          in_sr_ff <= in_next;
          if (word_end) begin
            cfg_word_out  <= in_next;
            cfg_valid_out <= 1'b1;
          end
        end
        if (sel_out) begin
          // pad frame goes out as supplied; dropping it is the reader's job
          out_sr_ff      <= word_end ? frame_data_in : {out_sr_ff[30:0], 1'b0};
          frame_take_out <= word_end;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tdo_ff            <= 1'b0;
      rti_cnt_ff        <= 8'h00;
      shutdown_done_out <= 1'b0;
      startup_done_out  <= 1'b0;
    end else begin
      shutdown_done_out <= rise && rti_hit && sel_shut;
      startup_done_out  <= rise && rti_hit && sel_strt;
      if (rise) begin
        rti_cnt_ff <= (state_ff != jsr_pkg::RTI) ? 8'h00 :
                      (rti_hit ? rti_cnt_ff : rti_cnt_ff + 8'h01);
      end
      if (fall) begin
        // readback data leaves in shift-dr of the output register; in shift-ir tdo carries ir_sr_ff[0]
        tdo_ff <= (in_sh_dr && sel_out) ? out_sr_ff[31] :
                  (state_ff == jsr_pkg::SH_IR) ? ir_sr_ff[0] : 1'b0;
      end
    end
  end
endmodule : jsr_dev
`default_nettype wire

// ===== verilog/jsr_host.sv
// How it works
// - host opens with five TMS-high clocks
// - TMS 0, 1,1, 0,0 into Shift-IR
// - instruction LSB first, MSB with TMS high
// - device decodes shutdown_instr opcode
// - Update-IR then twelve idle clocks for shutdown
// - device selects configuration-input register on opcode
// - after IR, TMS 1,1 then 0,0
// - packets MSB first, last LSB with TMS high
// - host shifts the eight readback setup words
// - after DR, TMS 1,1,1 then 0,0
// - device selects frame_readout_reg output register on opcode
// - readback bits out on TDO, last with TMS
// - host reloads input instruction, shifts restart words
// - one TMS-high clock into Update-DR
// - startup_instr then twelve idle clocks
// - host ends with five TMS-high clocks
// - opcode width and values are parameters
// - first readback frame is pad, discarded
`include "jsr_cfg.svh"
`default_nettype none
module jsr_host #(
  parameter int              IR_W        = `JSR_IR_W,
  parameter logic [IR_W-1:0] OP_SHUTDOWN = `JSR_OP_SHUTDOWN,
  parameter logic [IR_W-1:0] OP_CFG_IN   = `JSR_OP_CFG_IN,
  parameter logic [IR_W-1:0] OP_CFG_OUT  = `JSR_OP_CFG_OUT,
  parameter logic [IR_W-1:0] OP_STARTUP  = `JSR_OP_STARTUP,
  parameter int              TCK_DIV     = `JSR_TCK_DIV,
  parameter logic [31:0]     FRAME_WORDS = `JSR_FRAME_WORDS
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  jsr_link_if.host         link,
  input  wire logic        start_in,
  input  wire logic [31:0] rb_bits_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [31:0]      rd_word_out,
  output logic             rd_valid_out,
  input  wire logic        rd_ready_in
);
  localparam logic [4:0] LAST_STEP = 5'h1F;
  localparam logic [7:0] PH_HI     = 8'(TCK_DIV);
  localparam logic [7:0] PH_END    = 8'(2 * TCK_DIV - 1);

  function automatic jsr_pkg::jsr_seg_s mk(input jsr_pkg::jsr_kind_e k, input logic t,
                                           input logic [31:0] n, input logic [15:0] a);
    mk = '{kind: k, tms: t, len: n, arg: a};
  endfunction : mk

  function automatic jsr_pkg::jsr_seg_s hst_seg(input logic [4:0] s, input logic [31:0] rb);
    case (s)
      5'h00:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, `JSR_TLR_TCKS, 16'h0000);
      5'h01:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h1, 16'h0000);
      5'h02:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h03:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h04:   hst_seg = mk(jsr_pkg::K_IR, 1'b0, 32'(IR_W), 16'(OP_SHUTDOWN));
      5'h05:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h1, 16'h0000);
      5'h06:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'(`JSR_RTI_TCKS), 16'h0000);
      5'h07:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h08:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h09:   hst_seg = mk(jsr_pkg::K_IR, 1'b0, 32'(IR_W), 16'(OP_CFG_IN));
      5'h0A:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h0B:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h0C:   hst_seg = mk(jsr_pkg::K_DW, 1'b0, `JSR_PKT_BITS, 16'h0000);
      5'h0D:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h3, 16'h0000);
      5'h0E:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h0F:   hst_seg = mk(jsr_pkg::K_IR, 1'b0, 32'(IR_W), 16'(OP_CFG_OUT));
      5'h10:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h11:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h12:   hst_seg = mk(jsr_pkg::K_DR, 1'b0, (rb == 32'h0) ? 32'h1 : rb, 16'h0000);
      5'h13:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h3, 16'h0000);
      5'h14:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h15:   hst_seg = mk(jsr_pkg::K_IR, 1'b0, 32'(IR_W), 16'(OP_CFG_IN));
      5'h16:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h17:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h18:   hst_seg = mk(jsr_pkg::K_DW, 1'b0, `JSR_PKT_BITS, 16'h0001);
      5'h19:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h1, 16'h0000);
      // update-dr to shift-ir still needs select-dr, select-ir, capture-ir
      5'h1A:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h2, 16'h0000);
      5'h1B:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'h2, 16'h0000);
      5'h1C:   hst_seg = mk(jsr_pkg::K_IR, 1'b0, 32'(IR_W), 16'(OP_STARTUP));
      5'h1D:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, 32'h1, 16'h0000);
      5'h1E:   hst_seg = mk(jsr_pkg::K_MOVE, 1'b0, 32'(`JSR_RTI_TCKS), 16'h0000);
      default: hst_seg = mk(jsr_pkg::K_MOVE, 1'b1, `JSR_TLR_TCKS, 16'h0000);
    endcase
  endfunction : hst_seg

  function automatic logic [31:0] hst_word(input logic set, input logic [2:0] i);
    case ({set, i})
      4'h0:    hst_word = `JSR_SETUP_W0;
      4'h1:    hst_word = `JSR_SETUP_W1;
      4'h2:    hst_word = `JSR_SETUP_W2;
      4'h3:    hst_word = `JSR_SETUP_W3;
      4'h4:    hst_word = `JSR_SETUP_W4;
      4'h5:    hst_word = `JSR_SETUP_W5;
      4'h6:    hst_word = `JSR_SETUP_W6;
      4'h7:    hst_word = `JSR_SETUP_W7;
      4'h8:    hst_word = `JSR_RESTART_W0;
      4'h9:    hst_word = `JSR_RESTART_W1;
      4'hA:    hst_word = `JSR_RESTART_W2;
      4'hB:    hst_word = `JSR_RESTART_W3;
      4'hC:    hst_word = `JSR_RESTART_W4;
      4'hD:    hst_word = `JSR_RESTART_W5;
      4'hE:    hst_word = `JSR_RESTART_W6;
      default: hst_word = `JSR_RESTART_W7;
    endcase
  endfunction : hst_word

  jsr_pkg::jsr_hst_e hst_ff;
  logic [4:0]        step_ff;
  logic [31:0]       bit_ff, rb_bits_ff, pad_cnt_ff, rd_sr_ff, skid_ff;
  logic [7:0]        ph_ff;
  logic              tck_ff, tms_ff, tdi_ff, tdo_s1_ff, tdo_s2_ff, skid_v_ff;

  jsr_pkg::jsr_seg_s seg;
  assign seg = hst_seg(step_ff, rb_bits_ff);

  wire        running  = (hst_ff == jsr_pkg::H_RUN);
  wire        last_bit = (bit_ff == seg.len - 32'h1);
  wire        shifting = (seg.kind != jsr_pkg::K_MOVE);
  wire        full     = rd_valid_out & skid_v_ff;
  wire        go_bit   = running && (ph_ff == 8'h00) && !full;
  wire        sample   = running && (ph_ff == PH_END);
  wire [31:0] cur_word = hst_word(seg.arg[0], bit_ff[7:5]);
  wire        bit_tms  = (shifting && last_bit) ? 1'b1 : seg.tms;
  wire        bit_tdi  = (seg.kind == jsr_pkg::K_IR) ? seg.arg[bit_ff[3:0]] :
                         (seg.kind == jsr_pkg::K_DW) ? cur_word[~bit_ff[4:0]] : 1'b0;
  wire        word_in  = sample && (seg.kind == jsr_pkg::K_DR) && (bit_ff[4:0] == `JSR_WORD_LAST);
  wire        pad_done = (pad_cnt_ff >= FRAME_WORDS);
  wire        push     = word_in && pad_done;
  wire        pop      = rd_valid_out & rd_ready_in;
  wire [31:0] rd_next  = {rd_sr_ff[30:0], tdo_s2_ff};

  assign link.tck = tck_ff;
  assign link.tms = tms_ff;
  assign link.tdi = tdi_ff;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      {tdo_s1_ff, tdo_s2_ff} <= 2'h0;
    end else begin
      {tdo_s1_ff, tdo_s2_ff} <= {link.tdo, tdo_s1_ff};
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hst_ff     <= jsr_pkg::H_IDLE;
      step_ff    <= 5'h00;
      bit_ff     <= 32'h0;
      ph_ff      <= 8'h00;
      rb_bits_ff <= 32'h0;
      busy_out   <= 1'b0;
      done_out   <= 1'b0;
      tck_ff     <= 1'b0;
      tms_ff     <= 1'b1;
      tdi_ff     <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (hst_ff)
        jsr_pkg::H_IDLE: if (start_in) begin
          hst_ff     <= jsr_pkg::H_RUN;
          rb_bits_ff <= rb_bits_in;
          step_ff    <= 5'h00;
          bit_ff     <= 32'h0;
          ph_ff      <= 8'h00;
          busy_out   <= 1'b1;
        end
        jsr_pkg::H_RUN: begin
          if (go_bit) begin
            tck_ff <= 1'b0;
            tms_ff <= bit_tms;
            tdi_ff <= bit_tdi;
            ph_ff  <= 8'h01;
          end else if (ph_ff != 8'h00) begin
            ph_ff <= sample ? 8'h00 : ph_ff + 8'h01;
            if (ph_ff == PH_HI) tck_ff <= 1'b1;
          end
          if (sample) begin
            bit_ff <= last_bit ? 32'h0 : bit_ff + 32'h1;
            if (last_bit) step_ff <= step_ff + 5'h01;
            if (last_bit && step_ff == LAST_STEP) begin
              hst_ff   <= jsr_pkg::H_IDLE;
              busy_out <= 1'b0;
              done_out <= 1'b1;
            end
          end
        end
        default: hst_ff <= jsr_pkg::H_IDLE;
      endcase
    end
  end

  // readback words collect MSB first; a full buffer stalls tck
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_sr_ff   <= 32'h0;
      pad_cnt_ff <= 32'h0;
    end else begin
      if (hst_ff == jsr_pkg::H_IDLE) pad_cnt_ff <= 32'h0;
      else if (word_in && !pad_done) pad_cnt_ff <= pad_cnt_ff + 32'h1;
      if (sample && seg.kind == jsr_pkg::K_DR) rd_sr_ff <= rd_next;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_word_out  <= 32'h0;
      rd_valid_out <= 1'b0;
      skid_ff      <= 32'h0;
      skid_v_ff    <= 1'b0;
    end else if (pop || !rd_valid_out) begin
      if (skid_v_ff) begin
        rd_word_out  <= skid_ff;
        rd_valid_out <= 1'b1;
        skid_v_ff    <= push;
        if (push) skid_ff <= rd_next;
      end else begin
        rd_valid_out <= push;
        if (push) rd_word_out <= rd_next;
      end
    end else if (push) begin
      skid_ff   <= rd_next;
      skid_v_ff <= 1'b1;
    end
  end
endmodule : jsr_host
`default_nettype wire

// ===== verilog/jsr_link_if.sv
`default_nettype none
interface jsr_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  modport dev  (input tck, input tms, input tdi, output tdo);
  modport host (output tck, output tms, output tdi, input tdo);
endinterface : jsr_link_if
`default_nettype wire

// ===== verilog/jsr_pkg.sv
`default_nettype none
package jsr_pkg;
  typedef enum logic [3:0] {
    TLR    = 4'h0, RTI    = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR  = 4'h4, EX1_DR = 4'h5, PA_DR  = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR  = 4'hB,
    EX1_IR = 4'hC, PA_IR  = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
  } jsr_tap_e;
  typedef enum logic [1:0] {
    K_MOVE = 2'h0, K_IR = 2'h1, K_DW = 2'h2, K_DR = 2'h3
  } jsr_kind_e;
  typedef enum logic [0:0] {H_IDLE = 1'h0, H_RUN = 1'h1} jsr_hst_e;
  // one host segment: kind, tms level, bit count, opcode or packet set
  typedef struct packed {
    jsr_kind_e   kind;
    logic        tms;
    logic [31:0] len;
    logic [15:0] arg;
  } jsr_seg_s;
endpackage : jsr_pkg
`default_nettype wire
